// ### rtl/spgc_ctrl_status.sv
// Global control and status register bank of the scaler output port.
`timescale 1ns/1ps
module spgc_ctrl_status
(
    input  wire logic                        clk_sys_in,
    input  wire logic                        rst_n_in,
    input  wire logic [spgc_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic                        reg_wr_in,
    input  wire logic [spgc_pkg::DATA_W-1:0] reg_wdata_in,
    output logic      [spgc_pkg::DATA_W-1:0] reg_rdata_out,
    input  wire logic                        gated_clock_mode_bit_in,
    input  wire logic                        scaler_clocks_from_xport_in,
    input  wire logic                        image_port_three_state_pin_in,
    input  wire logic                        expansion_port_three_state_pin_in,
    input  wire logic                        fifo_almost_filled_flag_in,
    input  wire logic                        fifo_overflow_flag_in,
    input  wire logic                        formatter_error_flag_in,
    input  wire logic                        scaler_input_field_id_in,
    input  wire logic                        scaler_output_field_id_in,
    input  wire logic [spgc_pkg::RAW_W-1:0]  conv0_sample_in,
    input  wire logic [spgc_pkg::RAW_W-1:0]  conv1_sample_in,
    input  wire logic [spgc_pkg::RAW_W-1:0]  conv2_sample_in,
    input  wire logic [spgc_pkg::RAW_W-1:0]  conv3_sample_in,
    output logic      [1:0]                  out_clk_phase_sel_out,
    output logic      [1:0]                  gated_clk_phase_sel_out,
    output logic                             image_port_drive_en_out,
    output logic                             scaler_hold_reset_out,
    output logic                             scaler_run_allowed_out,
    output logic                             decoder_power_down_out,
    output logic                             scaler_power_down_out,
    output logic                             audio_clk_power_down_out,
    output logic      [spgc_pkg::RAW_W-1:0]  raw_converter_output_port_out
);
    import spgc_pkg::*;

    logic [7:0]       port_ctrl_r;
    logic [7:0]       port_ctrl_nxt;
    logic [7:0]       power_ctrl_r;
    logic [7:0]       power_ctrl_nxt;
    logic [1:0]       image_port_three_state_pin_sync_r;
    logic [1:0]       image_port_three_state_pin_sync_nxt;
    logic [1:0]       expansion_port_three_state_pin_sync_r;
    logic [1:0]       expansion_port_three_state_pin_sync_nxt;
    logic [7:0]       status_byte;
    logic [7:0]       rdata_r;
    logic [7:0]       rdata_nxt;
    logic [1:0]       out_ph_r;
    logic [1:0]       out_ph_nxt;
    logic [1:0]       gated_ph_r;
    logic [1:0]       gated_ph_nxt;
    logic             drive_en_r;
    logic             drive_en_nxt;
    logic             hold_rst_r;
    logic             hold_rst_nxt;
    logic             run_ok_r;
    logic             run_ok_nxt;
    logic             dec_pd_r;
    logic             dec_pd_nxt;
    logic             scl_pd_r;
    logic             scl_pd_nxt;
    logic             aud_pd_r;
    logic             aud_pd_nxt;
    logic [RAW_W-1:0] raw_r;
    logic [RAW_W-1:0] raw_nxt;

    // Register writes; the status address is not decoded for writes.
    always_comb
    begin
        port_ctrl_nxt  = port_ctrl_r;
        power_ctrl_nxt = power_ctrl_r;
        if (reg_wr_in && reg_addr_in == ADDR_PORT_CTRL)
        begin
            port_ctrl_nxt = reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == ADDR_POWER_CTRL)
        begin
            power_ctrl_nxt = reg_wdata_in;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            port_ctrl_r  <= PORT_CTRL_RST;
            power_ctrl_r <= POWER_CTRL_RST;
        end
        else
        begin
            port_ctrl_r  <= port_ctrl_nxt;
            power_ctrl_r <= power_ctrl_nxt;
        end
    end

    // The three-state pins are asynchronous to this clock.
    always_comb
    begin
        image_port_three_state_pin_sync_nxt = {image_port_three_state_pin_sync_r[0], image_port_three_state_pin_in};
        expansion_port_three_state_pin_sync_nxt = {expansion_port_three_state_pin_sync_r[0], expansion_port_three_state_pin_in};
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            image_port_three_state_pin_sync_r <= 2'h0;
            expansion_port_three_state_pin_sync_r <= 2'h0;
        end
        else
        begin
            image_port_three_state_pin_sync_r <= image_port_three_state_pin_sync_nxt;
            expansion_port_three_state_pin_sync_r <= expansion_port_three_state_pin_sync_nxt;
        end
    end

    // Flags are sampled as they stand, with no capture or hold, so a
    // short pulse between two reads is not seen.
    always_comb
    begin
        status_byte = {expansion_port_three_state_pin_sync_r[1], image_port_three_state_pin_sync_r[1],
                       fifo_almost_filled_flag_in,
                       fifo_overflow_flag_in,
                       power_ctrl_r[MARKER_BIT],
                       formatter_error_flag_in,
                       scaler_input_field_id_in,
                       scaler_output_field_id_in};
        case (reg_addr_in)
            ADDR_PORT_CTRL:  rdata_nxt = port_ctrl_r;
            ADDR_POWER_CTRL: rdata_nxt = power_ctrl_r;
            ADDR_STATUS:     rdata_nxt = status_byte;
            default:         rdata_nxt = UNMAPPED_RDATA;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            rdata_r <= UNMAPPED_RDATA;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // Output controls, registered one cycle behind the register bank.
    always_comb
    begin
        out_ph_nxt = port_ctrl_r[OUT_PH_MSB:OUT_PH_LSB];
        if (gated_clock_mode_bit_in)
        begin
            gated_ph_nxt = port_ctrl_r[GATED_PH_MSB:GATED_PH_LSB];
        end
        else
        begin
            gated_ph_nxt = PHASE_DEFAULT;
        end
        if (port_ctrl_r[PIN_MODE_BIT])
        begin
            drive_en_nxt = image_port_three_state_pin_sync_r[1] == port_ctrl_r[EN_LEVEL_BIT];
        end
        else
        begin
            drive_en_nxt = port_ctrl_r[EN_LEVEL_BIT];
        end
        if (power_ctrl_r[SCALER_PD_BIT])
        begin
            drive_en_nxt = 1'b0;
        end
        hold_rst_nxt = !power_ctrl_r[SOFT_RST_BIT];
        dec_pd_nxt   = power_ctrl_r[DECODER_PD_BIT];
        run_ok_nxt   = !power_ctrl_r[SCALER_PD_BIT] &&
                       !hold_rst_nxt &&
                       (!dec_pd_nxt ||
                        scaler_clocks_from_xport_in);
        scl_pd_nxt   = power_ctrl_r[SCALER_PD_BIT];
        aud_pd_nxt   = power_ctrl_r[AUDIO_PD_BIT];
        case (power_ctrl_r[CONV_SEL_MSB:CONV_SEL_LSB])
            2'h0:    raw_nxt = conv0_sample_in;
            2'h1:    raw_nxt = conv1_sample_in;
            2'h2:    raw_nxt = conv2_sample_in;
            default: raw_nxt = conv3_sample_in;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            out_ph_r   <= PHASE_DEFAULT;
            gated_ph_r <= PHASE_DEFAULT;
            drive_en_r <= 1'b0;
            hold_rst_r <= 1'b1;
            run_ok_r   <= 1'b0;
            dec_pd_r   <= 1'b0;
            scl_pd_r   <= 1'b0;
            aud_pd_r   <= 1'b0;
            raw_r      <= '0;
        end
        else
        begin
            out_ph_r   <= out_ph_nxt;
            gated_ph_r <= gated_ph_nxt;
            drive_en_r <= drive_en_nxt;
            hold_rst_r <= hold_rst_nxt;
            run_ok_r   <= run_ok_nxt;
            dec_pd_r   <= dec_pd_nxt;
            scl_pd_r   <= scl_pd_nxt;
            aud_pd_r   <= aud_pd_nxt;
            raw_r      <= raw_nxt;
        end
    end

    assign reg_rdata_out                 = rdata_r;
    assign out_clk_phase_sel_out         = out_ph_r;
    assign gated_clk_phase_sel_out       = gated_ph_r;
    assign image_port_drive_en_out       = drive_en_r;
    assign scaler_hold_reset_out         = hold_rst_r;
    assign scaler_run_allowed_out        = run_ok_r;
    assign decoder_power_down_out        = dec_pd_r;
    assign scaler_power_down_out         = scl_pd_r;
    assign audio_clk_power_down_out      = aud_pd_r;
    assign raw_converter_output_port_out = raw_r;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    property p_out_phase;
        reg_wr_in && reg_addr_in == ADDR_PORT_CTRL
        |=> ##1 out_clk_phase_sel_out ==
            $past(reg_wdata_in[OUT_PH_MSB:OUT_PH_LSB], 2);
    endproperty
    a_out_phase: assert property (p_out_phase)
        else $error("output clock phase does not follow write");

    property p_gated_phase;
        !$past(gated_clock_mode_bit_in) |-> gated_clk_phase_sel_out == 2'h0;
    endproperty
    a_gated_phase: assert property (p_gated_phase)
        else $error("gated phase applied while gated mode off");

    property p_gated_follow;
        $past(gated_clock_mode_bit_in)
        |-> gated_clk_phase_sel_out ==
            $past(port_ctrl_r[GATED_PH_MSB:GATED_PH_LSB]);
    endproperty
    a_gated_follow: assert property (p_gated_follow)
        else $error("gated phase does not follow its field");

    property p_drive_en;
        $past(power_ctrl_r[1]) |-> !image_port_drive_en_out;
    endproperty
    a_drive_en: assert property (p_drive_en)
        else $error("image port driven in scaler power save");

    property p_pin_enable;
        $past(port_ctrl_r[1:0]) == 2'h2 && !$past(power_ctrl_r[1])
        |-> image_port_drive_en_out == !$past(image_port_three_state_pin_sync_r[1]);
    endproperty
    a_pin_enable: assert property (p_pin_enable)
        else $error("pin controlled enable has wrong sense");

    property p_marker_echo;
        reg_wr_in && reg_addr_in == ADDR_POWER_CTRL ##1
        !reg_wr_in ##1
        reg_addr_in == ADDR_STATUS && !reg_wr_in
        |=> reg_rdata_out[3] == $past(reg_wdata_in[MARKER_BIT], 3);
    endproperty
    a_marker_echo: assert property (p_marker_echo)
        else $error("status marker echo differs from written marker");

    property p_status_write;
        reg_wr_in && reg_addr_in == ADDR_STATUS
        |=> $stable(port_ctrl_r) && $stable(power_ctrl_r);
    endproperty
    a_status_write: assert property (p_status_write)
        else $error("write to status byte changed a register");

    property p_soft_reset;
        !$past(power_ctrl_r[SOFT_RST_BIT])
        |-> scaler_hold_reset_out && !scaler_run_allowed_out;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("scaler not held while soft reset bit is zero");

    property p_raw_sel;
        $past(power_ctrl_r[7:6]) == 2'h2
        |-> raw_converter_output_port_out == $past(conv2_sample_in);
    endproperty
    a_raw_sel: assert property (p_raw_sel)
        else $error("raw port does not carry selected converter");

    property p_decoder_pd;
        $past(power_ctrl_r[0]) && !$past(scaler_clocks_from_xport_in)
        |-> decoder_power_down_out && !scaler_run_allowed_out;
    endproperty
    a_decoder_pd: assert property (p_decoder_pd)
        else $error("scaler runs with decoder down and local clocks");
endmodule

// ### rtl/spgc_pkg.sv
// Package with register map, field positions and reset values of the block.
package spgc_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          RAW_W           = 9;
    localparam logic [7:0]  ADDR_PORT_CTRL  = 8'h87;
    localparam logic [7:0]  ADDR_POWER_CTRL = 8'h88;
    localparam logic [7:0]  ADDR_STATUS     = 8'h8F;
    localparam logic [7:0]  PORT_CTRL_RST   = 8'h00;
    localparam logic [7:0]  POWER_CTRL_RST  = 8'h00;
    localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;
    // Fields of the output port clock and enable register.
    localparam int          GATED_PH_MSB    = 7;
    localparam int          GATED_PH_LSB    = 6;
    localparam int          OUT_PH_MSB      = 5;
    localparam int          OUT_PH_LSB      = 4;
    localparam int          PIN_MODE_BIT    = 1;
    localparam int          EN_LEVEL_BIT    = 0;
    // Fields of the converter port, reset and power register.
    localparam int          CONV_SEL_MSB    = 7;
    localparam int          CONV_SEL_LSB    = 6;
    localparam int          SOFT_RST_BIT    = 5;
    localparam int          MARKER_BIT      = 4;
    localparam int          AUDIO_PD_BIT    = 3;
    localparam int          SCALER_PD_BIT   = 1;
    localparam int          DECODER_PD_BIT  = 0;
    // Phase select codes, shared by both clock outputs.
    localparam logic [1:0]  PHASE_DEFAULT   = 2'h0;
    localparam logic [1:0]  PHASE_HALF      = 2'h1;
    localparam logic [1:0]  PHASE_TRIM      = 2'h2;
    localparam logic [1:0]  PHASE_HALF_TRIM = 2'h3;
    localparam int          PHASE_TRIM_NS   = 3;
endpackage

// ### sim/spgc_host_model.sv
// Register bus host model that issues byte writes and reads to the bank.
`timescale 1ns/1ps
module spgc_host_model
(
    input  wire logic                          clk_sys_in,
    input  wire logic [spgc_pkg::DATA_W-1:0]   reg_rdata_in,
    output logic      [spgc_pkg::ADDR_W-1:0]   reg_addr_out,
    output logic                               reg_wr_out,
    output logic      [spgc_pkg::DATA_W-1:0]   reg_wdata_out
);
    import spgc_pkg::*;

    initial
    begin
        reg_addr_out  = 8'h00;
        reg_wr_out    = 1'b0;
        reg_wdata_out = 8'h00;
    end

    // One-cycle write strobe; data is scrambled after the strobe so that a
    // design sampling it late sees a wrong value.
    task automatic wr_reg(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge clk_sys_in);
        reg_addr_out  <= a;
        reg_wdata_out <= d;
        reg_wr_out    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_out    <= 1'b0;
        reg_wdata_out <= ~d;
    endtask

    // Read data is registered, so it is taken one edge after the address.
    task automatic rd_reg(input  logic [ADDR_W-1:0] a,
                          output logic [DATA_W-1:0] d);
        @(posedge clk_sys_in);
        reg_addr_out <= a;
        @(posedge clk_sys_in);
        #1;
        d = reg_rdata_in;
    endtask
endmodule

// ### sim/testbench.sv
// Self-checking testbench of the scaler port control and status bank.
`timescale 1ns/1ps
module testbench;
    import spgc_pkg::*;
    logic             clk_sys;
    logic             rst_n;
    logic [7:0]       addr;
    logic             wr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic             gmode, xport, image_port_three_state_pin, expansion_port_three_state_pin, fifo_almost_filled_flag, fifo_overflow_flag, ferr, fidi, fido;
    logic [8:0]       conv_s [4];
    logic [1:0]       oph, gph;
    logic             drv, hold, run, dec, scl, aud;
    logic [8:0]       raw;
    logic [7:0]       rd;
    logic [7:0]       stat;
    logic [8:0]       ctl_v;
    int               n_errors = 0;
    int               samples_checked = 0;

    assign ctl_v = {3'h0, hold, run, drv, dec, scl, aud};

    spgc_ctrl_status i_dut
    (
        .clk_sys_in                        (clk_sys),
        .rst_n_in                          (rst_n),
        .reg_addr_in                       (addr),
        .reg_wr_in                         (wr),
        .reg_wdata_in                      (wdata),
        .reg_rdata_out                     (rdata),
        .gated_clock_mode_bit_in           (gmode),
        .scaler_clocks_from_xport_in       (xport),
        .image_port_three_state_pin_in     (image_port_three_state_pin),
        .expansion_port_three_state_pin_in (expansion_port_three_state_pin),
        .fifo_almost_filled_flag_in        (fifo_almost_filled_flag),
        .fifo_overflow_flag_in             (fifo_overflow_flag),
        .formatter_error_flag_in           (ferr),
        .scaler_input_field_id_in          (fidi),
        .scaler_output_field_id_in         (fido),
        .conv0_sample_in                   (conv_s[0]),
        .conv1_sample_in                   (conv_s[1]),
        .conv2_sample_in                   (conv_s[2]),
        .conv3_sample_in                   (conv_s[3]),
        .out_clk_phase_sel_out             (oph),
        .gated_clk_phase_sel_out           (gph),
        .image_port_drive_en_out           (drv),
        .scaler_hold_reset_out             (hold),
        .scaler_run_allowed_out            (run),
        .decoder_power_down_out            (dec),
        .scaler_power_down_out             (scl),
        .audio_clk_power_down_out          (aud),
        .raw_converter_output_port_out     (raw)
    );

    spgc_host_model i_host
    (
        .clk_sys_in    (clk_sys),
        .reg_rdata_in  (rdata),
        .reg_addr_out  (addr),
        .reg_wr_out    (wr),
        .reg_wdata_out (wdata)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check_vec(input string nm, input logic [8:0] exp,
                             input logic [8:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    // Three edges cover the two-flop pin synchroniser plus the output stage.
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #200000;
        $display("[FAIL] watchdog expected end seen hang");
        n_errors++;
        finish_test();
    end

    initial
    begin
        rst_n = 1'b0;
        {gmode, xport, image_port_three_state_pin, expansion_port_three_state_pin, fifo_almost_filled_flag, fifo_overflow_flag, ferr, fidi, fido} = 9'h000;
        conv_s[0] = 9'h1A5;
        conv_s[1] = 9'h05A;
        conv_s[2] = 9'h133;
        conv_s[3] = 9'h0CC;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(2);
        check_vec("reset outs", 9'h020, ctl_v);
        check_vec("reset phases", 9'h000, {5'h00, oph, gph});
        i_host.rd_reg(ADDR_POWER_CTRL, rd);
        check_vec("power reset", {1'b0, POWER_CTRL_RST}, {1'b0, rd});
        i_host.rd_reg(ADDR_PORT_CTRL, rd);
        check_vec("port reset", {1'b0, PORT_CTRL_RST}, {1'b0, rd});
        i_host.rd_reg(ADDR_STATUS, rd);
        check_vec("marker reset", 9'h000, {1'b0, rd});
        $display("test reset done");
        // Code 01 is the choice the host should prefer for both clocks.
        for (int c = 0; c < 4; c++)
            for (int g = 0; g < 2; g++)
            begin
                @(posedge clk_sys);
                gmode <= g[0];
                i_host.wr_reg(ADDR_PORT_CTRL,
                              {~c[1:0], c[1:0], 4'h0});
                settle(2);
                check_vec("out phase", {7'h00, c[1:0]},
                          {7'h00, oph});
                check_vec("gated phase", {7'h00, g[0] ? ~c[1:0] : 2'h0},
                          {7'h00, gph});
            end
        $display("test phases done");
        for (int m = 0; m < 4; m++)
            for (int p = 0; p < 2; p++)
            begin
                @(posedge clk_sys);
                image_port_three_state_pin <= p[0];
                i_host.wr_reg(ADDR_PORT_CTRL, {6'h00, m[1:0]});
                settle(4);
                check_vec("drive enable",
                          {8'h00, m[1] ? (p[0] == m[0]) : m[0]},
                          {8'h00, drv});
            end
        $display("test enable done");
        i_host.wr_reg(ADDR_PORT_CTRL, 8'h01);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_sys);
            xport <= i[3];
            i_host.wr_reg(ADDR_POWER_CTRL,
                          {2'h0, 1'b1, 1'b0, i[2], 1'b0, i[1], i[0]});
            settle(2);
            check_vec("power outs", {3'h0, 1'b0, !i[1] && (!i[0] || i[3]),
                      !i[1], i[0], i[1], i[2]},
                      ctl_v);
        end
        $display("test power done");
        for (int k = 0; k < 4; k++)
        begin
            i_host.wr_reg(ADDR_POWER_CTRL, {k[1:0], 6'h20});
            settle(2);
            check_vec("raw port", conv_s[k], raw);
        end
        $display("test converter done");
        for (int b = 0; b < 8; b++)
        begin
            stat = 8'h01 << b;
            @(posedge clk_sys);
            {expansion_port_three_state_pin, image_port_three_state_pin, fifo_almost_filled_flag, fifo_overflow_flag} <= stat[7:4];
            {ferr, fidi, fido} <= stat[2:0];
            i_host.wr_reg(ADDR_POWER_CTRL, {3'h1, stat[3], 4'h0});
            i_host.rd_reg(ADDR_STATUS, rd);
            check_vec("status", {1'b0, stat},
                      {1'b0, rd});
        end
        $display("test status done");
        i_host.wr_reg(ADDR_STATUS, 8'hFF);
        i_host.wr_reg(8'h90, 8'hFF);
        i_host.rd_reg(ADDR_STATUS, rd);
        check_vec("status after write", 9'h080, {1'b0, rd});
        i_host.rd_reg(ADDR_PORT_CTRL, rd);
        check_vec("port after write", 9'h001, {1'b0, rd});
        i_host.rd_reg(ADDR_POWER_CTRL, rd);
        check_vec("power after write", 9'h020, {1'b0, rd});
        i_host.rd_reg(8'h90, rd);
        check_vec("unmapped", {1'b0, UNMAPPED_RDATA}, {1'b0, rd});
        $display("test read only done");
        finish_test();
    end
endmodule
